// ---- hdl/uls_pkg.sv ----
/*
  Package for the extended status/control slice of the serial interface:
  register offsets, field positions, reset values, bit-time counts and
  the packed carriers shared by the slice and the bench.
  Assumes byte addresses on a 32-bit APB with one register per word.
*/
`default_nettype none
package uls_pkg;
  // ******************************
  // register offsets
  // ******************************
  localparam logic [7:0] ULS_STAT2_ADDR = 8'h00;
  localparam logic [7:0] ULS_CTL3_ADDR = 8'h04;
  localparam logic [7:0] ULS_AUX_ADDR = 8'h08;
  localparam logic [7:0] ULS_IRQ_STAT_ADDR = 8'h0c;
  localparam logic [7:0] ULS_IRQ_CLR_ADDR = 8'h10;
  localparam logic [7:0] ULS_IRQ_EN_ADDR = 8'h14;
  // ******************************
  // field positions
  // ******************************
  localparam int S2_LBK = 7;
  localparam int S2_EDGE = 6;
  localparam int S2_RX_INVERT = 4;
  localparam int S2_WID = 3;
  localparam int S2_LONG_BREAK_TX = 2;
  localparam int S2_LIN_BRK_DET_EN = 1;
  localparam int S2_RAF = 0;
  localparam int C3_R9 = 7;
  localparam int C3_T9 = 6;
  localparam int C3_DIR = 5;
  localparam int C3_TX_INVERT = 4;
  localparam int C3_OVERRUN_IRQ_EN = 3;
  localparam int C3_NOISE_IRQ_EN = 2;
  localparam int C3_FRAMING_IRQ_EN = 1;
  localparam int C3_PARITY_IRQ_EN = 0;
  localparam int AUX_NINE = 0;
  localparam int AUX_STBY = 1;
  localparam int AUX_LOOP = 2;
  localparam int AUX_RX_SRC_SEL = 3;
  localparam int EV_LBK = 0;
  localparam int EV_EDGE = 1;
  localparam int EV_IDLE = 2;
  // ******************************
  // reset values and bit-time counts
  // ******************************
  localparam logic [7:0] ULS_REG_RST = 8'h00;
  localparam logic [3:0] ULS_CHAR_BITS = 4'ha;
  localparam logic [3:0] ULS_LONG_BRK_EXTRA = 4'h3;
  // ******************************
  // carriers
  // ******************************
  typedef struct packed {
    logic done;
    logic ninth;
    logic stop_bit;
    logic parity_err;
    logic noise;
  } uls_rx_char_t;
  typedef struct packed {
    logic rx_full;
    logic framing;
    logic parity;
    logic noise;
    logic overrun;
    logic idle;
  } uls_err_flags_t;
endpackage
`default_nettype wire

// ---- hdl/uls_bit_cnt.sv ----
/*
  Bit-time counter: counts bit ticks while run is high and gives a
  one-cycle pulse when the count reaches limit; saturates there.
  Assumes tick is a single-cycle pulse on pclk from the baud generator.
*/
`timescale 1ns/1ps
`default_nettype none
module uls_bit_cnt #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // control
  input wire logic run,
  input wire logic tick,
  input wire logic [W-1:0] limit,
  // result
  output logic hit_q
);
  import uls_pkg::*;
  typedef struct packed {
    logic [W-1:0] cnt;
    logic hit;
  } uls_cnt_state_t;
  uls_cnt_state_t s;
  uls_cnt_state_t n;
  always_comb
  begin
    n = s;
    n.hit = 1'b0;
    if (!run)
    begin
      n.cnt = '0;
    end
    else if (tick && (s.cnt != limit))
    begin
      n.cnt = W'(s.cnt + 1'b1);
      n.hit = (W'(s.cnt + 1'b1) == limit);
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else if (ce)
      s <= n;
  end
  assign hit_q = s.hit;
endmodule
`default_nettype wire

// ---- hdl/uls_ctl.sv ----
/*
  Extended status/control slice of an asynchronous serial interface:
  LIN break detect, active-edge detect, polarity inversion, receiver
  active, wake-idle, break length, ninth bits, single-wire direction and
  error interrupt enables, reached over APB.
  Assumes the baud generator gives bit_tick and the shifters report
  characters and take loads on the same pclk; rx_pin, tx_pin_i are async.
*/
// Chosen here: the placing of the registers and the APB slave port.
// Function
// - enabled LIN break detection sets lin_brk_flag; writing one clears it
// - active rx edge sets rx_edge_flag, falling or rising per rx_invert
// - rx_invert inverts every received level, break and idle included
// - in standby, waking idle sets idle flag only if wake_idle_sets_idle
// - tx break lasts 10/11 or 13/14 bit times, framing check untouched
// - break detect threshold 10/11 bit times, 11/12 with lin_brk_det_en
// - lin_brk_det_en blocks framing error and rx_full_flag from setting
// - rx_active_flag set at start bit, cleared when idle line seen
// - tx load takes ninth_tx_bit as msb; the bit keeps its value
// - single-wire mode: tx pin direction follows single_wire_tx_dir
// - tx_invert inverts everything driven on tx pin
// - overrun flag with overrun_irq_en requests an interrupt
// - noise flag with noise_irq_en requests an interrupt
// - framing flag with framing_irq_en requests an interrupt
// - parity flag with parity_irq_en requests an interrupt
// - stop bit sampled low sets framing error with rx_full_flag
`timescale 1ns/1ps
`default_nettype none
module uls_ctl (
  // clock, reset, clock enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // baud generator and shifters
  input wire logic bit_tick,
  input wire uls_pkg::uls_rx_char_t rx_char,
  input wire logic data_rd,
  input wire logic tx_wr,
  input wire logic [7:0] tx_data,
  input wire logic brk_req,
  input wire logic tx_serial,
  output logic rx_line,
  output logic [8:0] shift_word,
  output logic shift_load,
  output uls_pkg::uls_err_flags_t err_flags,
  output logic tx_brk_busy,
  // pins
  input wire logic rx_pin,
  input wire logic tx_pin_i,
  output logic tx_pin_o,
  output logic tx_pin_oe,
  // interrupts
  output logic err_irq,
  output logic ev_irq
);
  import uls_pkg::*;
  // ******************************
  // state
  // ******************************
  typedef struct packed {
    logic [7:0] s2;
    logic [7:0] c3;
    logic [3:0] aux;
    logic [2:0] ev;
    logic [2:0] ev_en;
    uls_err_flags_t fl;
    logic [1:0] rx_sync;
    logic [1:0] tx_sync;
    logic rx_prev;
    logic rx_raw_prev;
    logic brk_on;
    logic [8:0] sw;
    logic load;
    logic txo;
    logic txoe;
    logic err_irq;
    logic ev_irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } uls_state_t;
  uls_state_t s;
  uls_state_t n;
  logic nine;
  logic single_wire;
  logic rx_raw;
  logic rx_cur;
  logic act_edge;
  logic rx_brk_hit;
  logic idle_hit;
  logic tx_brk_hit;
  logic [3:0] rx_brk_lim;
  logic [3:0] idle_lim;
  logic [3:0] tx_brk_lim;
  logic acc;
  logic wr;
  logic map_hit;
  logic [7:0] rd;
  logic idle_ev;
  // ******************************
  // receive line and limits
  // ******************************
  assign nine = s.aux[AUX_NINE];
  assign single_wire = s.aux[AUX_LOOP] & s.aux[AUX_RX_SRC_SEL];
  // loop without rx_src_sel listens to our own driven level
  assign rx_raw = single_wire ? s.tx_sync[1] : (s.aux[AUX_LOOP] ? s.txo : s.rx_sync[1]);
  assign rx_cur = rx_raw ^ s.s2[S2_RX_INVERT];
  // edge taken on the pin level, so a write to rx_invert alone is no edge
  assign act_edge = s.s2[S2_RX_INVERT] ? (rx_raw & ~s.rx_raw_prev)
    : (~rx_raw & s.rx_raw_prev);
  assign rx_brk_lim = 4'(ULS_CHAR_BITS + {3'h0, nine} + {3'h0, s.s2[S2_LIN_BRK_DET_EN]});
  assign idle_lim = 4'(ULS_CHAR_BITS + {3'h0, nine});
  assign tx_brk_lim = 4'(ULS_CHAR_BITS + {3'h0, nine}
    + (s.s2[S2_LONG_BREAK_TX] ? ULS_LONG_BRK_EXTRA : 4'h0));
  // ******************************
  // bit-time counters
  // ******************************
  // the counters saturate at their limit, so a long low line flags once
  uls_bit_cnt #(.W(4)) u_rx_brk (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(~rx_cur),
    .tick(bit_tick),
    .limit(rx_brk_lim),
    .hit_q(rx_brk_hit)
  );
  uls_bit_cnt #(.W(4)) u_idle (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(rx_cur),
    .tick(bit_tick),
    .limit(idle_lim),
    .hit_q(idle_hit)
  );
  uls_bit_cnt #(.W(4)) u_tx_brk (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(s.brk_on),
    .tick(bit_tick),
    .limit(tx_brk_lim),
    .hit_q(tx_brk_hit)
  );
  // ******************************
  // bus decode and read mux
  // ******************************
  // pready of the last cycle marks the access edge, so each access is taken once
  assign acc = psel & penable & ~s.pready;
  assign wr = psel & penable & s.pready & pwrite;
  assign idle_ev = idle_hit & s.s2[S2_RAF];
  always_comb
  begin
    map_hit = 1'b1;
    rd = 8'h00;
    case (paddr)
      ULS_STAT2_ADDR: rd = s.s2;
      ULS_CTL3_ADDR: rd = s.c3;
      ULS_AUX_ADDR: rd = {4'h0, s.aux};
      ULS_IRQ_STAT_ADDR: rd = {5'h00, s.ev};
      ULS_IRQ_CLR_ADDR: rd = 8'h00;
      ULS_IRQ_EN_ADDR: rd = {5'h00, s.ev_en};
      default: map_hit = 1'b0;
    endcase
  end
  // ******************************
  // next state
  // ******************************
  always_comb
  begin
    n = s;
    n.rx_sync = {s.rx_sync[0], rx_pin};
    n.tx_sync = {s.tx_sync[0], tx_pin_i};
    n.rx_prev = rx_cur;
    n.rx_raw_prev = rx_raw;
    // one wait state keeps every bus output on a flop
    n.pready = acc;
    n.pslverr = acc & ~map_hit;
    if (acc)
      n.prdata = {24'h000000, rd};
    if (wr && paddr == ULS_STAT2_ADDR)
    begin
      n.s2[S2_LBK] = s.s2[S2_LBK] & ~pwdata[S2_LBK];
      n.s2[S2_EDGE] = s.s2[S2_EDGE] & ~pwdata[S2_EDGE];
      n.s2[S2_RX_INVERT:S2_LIN_BRK_DET_EN] = pwdata[S2_RX_INVERT:S2_LIN_BRK_DET_EN];
    end
    if (wr && paddr == ULS_CTL3_ADDR)
      n.c3[C3_T9:C3_PARITY_IRQ_EN] = pwdata[C3_T9:C3_PARITY_IRQ_EN];
    if (wr && paddr == ULS_AUX_ADDR)
      n.aux = pwdata[3:0];
    if (wr && paddr == ULS_IRQ_CLR_ADDR)
      n.ev = s.ev & ~pwdata[2:0];
    if (wr && paddr == ULS_IRQ_EN_ADDR)
      n.ev_en = pwdata[2:0];
    // data read ends the clearing sequence; a new char the same cycle wins
    if (data_rd)
      n.fl = '0;
    // hardware sets come last so a set beats a clear in the same cycle
    if (rx_brk_hit && s.s2[S2_LIN_BRK_DET_EN])
    begin
      n.s2[S2_LBK] = 1'b1;
      n.ev[EV_LBK] = 1'b1;
    end
    // idle line closes a frame; a start in the same cycle opens the next
    if (idle_hit)
      n.s2[S2_RAF] = 1'b0;
    if (act_edge)
    begin
      n.s2[S2_EDGE] = 1'b1;
      n.ev[EV_EDGE] = 1'b1;
      n.s2[S2_RAF] = 1'b1;
    end
    if (idle_ev)
    begin
      n.ev[EV_IDLE] = 1'b1;
      if (!s.aux[AUX_STBY] || s.s2[S2_WID])
        n.fl.idle = 1'b1;
      n.aux[AUX_STBY] = 1'b0;
    end
    if (rx_char.done && !s.s2[S2_LIN_BRK_DET_EN])
    begin
      if (s.fl.rx_full && !data_rd)
        n.fl.overrun = 1'b1;
      else
      begin
        n.fl.rx_full = 1'b1;
        n.fl.framing = ~rx_char.stop_bit;
        n.fl.parity = rx_char.parity_err;
        n.fl.noise = rx_char.noise;
        n.c3[C3_R9] = rx_char.ninth & nine;
      end
    end
    // transmit side
    n.load = tx_wr;
    if (tx_wr)
      n.sw = {s.c3[C3_T9] & nine, tx_data};
    // a break request while one runs is dropped, not queued
    if (brk_req && !s.brk_on)
      n.brk_on = 1'b1;
    if (tx_brk_hit)
      n.brk_on = 1'b0;
    n.txo = (s.brk_on ? 1'b0 : tx_serial) ^ s.c3[C3_TX_INVERT];
    n.txoe = ~single_wire | s.c3[C3_DIR];
    // enabled flags of the last cycle, so the request lags a clear by one
    n.err_irq = (s.fl.overrun & s.c3[C3_OVERRUN_IRQ_EN])
      | (s.fl.noise & s.c3[C3_NOISE_IRQ_EN])
      | (s.fl.framing & s.c3[C3_FRAMING_IRQ_EN])
      | (s.fl.parity & s.c3[C3_PARITY_IRQ_EN]);
    n.ev_irq = |(s.ev & s.ev_en);
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.s2 <= ULS_REG_RST;
      s.c3 <= ULS_REG_RST;
      // sync flops and pin history start at the idle level: no false edge
      s.rx_sync <= 2'h3;
      s.tx_sync <= 2'h3;
      s.rx_prev <= 1'b1;
      s.rx_raw_prev <= 1'b1;
      s.txo <= 1'b1;
      s.txoe <= 1'b1;
    end
    else if (ce)
      s <= n;
  end
  // ******************************
  // outputs
  // ******************************
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign rx_line = s.rx_prev;
  assign shift_word = s.sw;
  assign shift_load = s.load;
  assign err_flags = s.fl;
  assign tx_brk_busy = s.brk_on;
  assign tx_pin_o = s.txo;
  assign tx_pin_oe = s.txoe;
  assign err_irq = s.err_irq;
  assign ev_irq = s.ev_irq;
  // ******************************
  // checks
  // ******************************
  // ticks counted while a break is on the line, apart from the counter
  logic [3:0] brk_ticks_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      brk_ticks_q <= 4'h0;
    else if (ce && !s.brk_on)
      brk_ticks_q <= 4'h0;
    else if (ce && bit_tick && brk_ticks_q != 4'hf)
      brk_ticks_q <= 4'(brk_ticks_q + 1'b1);
  end
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  lin_brk_set_a: assert property (ce && rx_brk_hit && s.s2[S2_LIN_BRK_DET_EN] |=> s.s2[S2_LBK])
    else $error("lin break not flagged");
  edge_flag_a: assert property (ce && s.rx_raw_prev != rx_raw
    && rx_raw == s.s2[S2_RX_INVERT] |=> s.s2[S2_EDGE] && s.ev[EV_EDGE])
    else $error("active edge not flagged");
  wake_idle_a: assert property (ce && idle_ev && s.aux[AUX_STBY] && !s.s2[S2_WID]
    && !s.fl.idle && !data_rd |=> !s.fl.idle)
    else $error("idle flag set on standby wake");
  tx_brk_len_a: assert property (ce && s.brk_on && tx_brk_hit |-> brk_ticks_q == tx_brk_lim)
    else $error("break length wrong");
  brk_inhibit_a: assert property (ce && s.s2[S2_LIN_BRK_DET_EN] && !s.fl.rx_full
    ##1 s.s2[S2_LIN_BRK_DET_EN] |-> (!s.fl.rx_full && !s.fl.framing) || $past(!ce))
    else $error("flags set under break detect");
  active_set_a: assert property (ce && s.rx_raw_prev && !rx_raw && !s.s2[S2_RX_INVERT]
    |=> s.s2[S2_RAF])
    else $error("active flag not set at start");
  active_clr_a: assert property (ce && idle_hit && !act_edge |=> !s.s2[S2_RAF])
    else $error("active flag not cleared at idle");
  ninth_tx_a: assert property (ce && tx_wr && nine |=> shift_load ##0 shift_word[8] == $past(s.c3[C3_T9]))
    else $error("ninth bit not loaded");
  tx_dir_a: assert property (ce && single_wire |=> tx_pin_oe == $past(s.c3[C3_DIR]))
    else $error("single-wire direction wrong");
  tx_inv_a: assert property (ce && !s.brk_on |=> tx_pin_o == ($past(tx_serial) ^ $past(s.c3[C3_TX_INVERT])))
    else $error("tx polarity wrong");
  err_irq_fall_a: assert property (ce
    && !(|{s.fl.overrun, s.fl.noise, s.fl.framing, s.fl.parity}) |=> !err_irq)
    else $error("error request without flag");
  // main scenarios
  brk_cover_c: cover property (s.s2[S2_LIN_BRK_DET_EN] && rx_brk_hit);
  tx_brk_cover_c: cover property (s.brk_on && tx_brk_hit);
  err_irq_cover_c: cover property (ce && !err_irq ##1 err_irq);
  edge_cover_c: cover property (ce && act_edge && s.s2[S2_RX_INVERT]);
  wake_cover_c: cover property (ce && idle_ev && s.aux[AUX_STBY]);
endmodule
`default_nettype wire

// ---- tb/uls_node_model.sv ----
/*
  Far-end serial node: drives the receive pin and, while the device
  releases it, the shared single-wire line.
  Assumes the bench sets its levels just after a pclk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module uls_node_model (
  // levels from the bench
  input wire logic inv,
  input wire logic send_low,
  // device pins
  input wire logic tx_pin_o,
  input wire logic tx_pin_oe,
  output logic rx_pin,
  output logic tx_pin_i
);
  // ******************************
  // line levels
  // ******************************
  // an inverted node idles low, so the device must undo it
  assign rx_pin = ~send_low ^ inv;
  // wire level: whoever holds the enable owns the line
  assign tx_pin_i = tx_pin_oe ? tx_pin_o : (~send_low ^ inv);
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
/*
  Self-checking bench for the status/control slice: APB tasks, shifter
  and baud stimulus, far-end node model.
  Assumes uls_pkg and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import uls_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, ce;
  logic [7:0] paddr, tx_data;
  logic [31:0] pwdata, prdata, q;
  logic bit_tick, data_rd, tx_wr, brk_req, tx_serial, rx_line, shift_load;
  logic tx_brk_busy, rx_pin, tx_pin_i, tx_pin_o, tx_pin_oe, err_irq, ev_irq;
  logic inv, send_low;
  logic [8:0] shift_word;
  uls_rx_char_t rx_char;
  uls_err_flags_t err_flags;
  int num_errors, samples_checked, n;
  logic [3:0] fault [4] = '{4'h6, 4'h0, 4'h5, 4'h4};
  logic [5:0] fexp [4] = '{6'h28, 6'h30, 6'h24, 6'h22};

  uls_ctl u_uls_ctl (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .bit_tick, .rx_char, .data_rd, .tx_wr,
    .tx_data, .brk_req, .tx_serial, .rx_line, .shift_word, .shift_load, .err_flags,
    .tx_brk_busy, .rx_pin, .tx_pin_i, .tx_pin_o, .tx_pin_oe, .err_irq, .ev_irq);
  uls_node_model u_uls_node_model (.inv, .send_low, .tx_pin_o, .tx_pin_oe, .rx_pin,
    .tx_pin_i);

  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ******************************
  // tasks
  // ******************************
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x)
    begin
      num_errors++;
      $display("BAD %0t seen %0h expected %0h", $time, s, x);
    end
  endtask

  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // slave wait states are not assumed; pready or the 20-cycle bound ends a wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      num_errors++;
      report_and_stop();
    end
  endtask

  task automatic tick(input int m);
    repeat (m)
    begin
      @(posedge pclk);
      bit_tick <= 1'b1;
      @(posedge pclk);
      bit_tick <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask

  task automatic pulse_rd;
    @(posedge pclk);
    data_rd <= 1'b1;
    @(posedge pclk);
    data_rd <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  // f is {ninth, stop bit, parity error, noise}
  task automatic char(input logic [3:0] f);
    @(posedge pclk);
    rx_char <= {1'b1, f};
    @(posedge pclk);
    rx_char <= '0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic txw(input logic [7:0] d);
    @(posedge pclk);
    tx_wr <= 1'b1;
    tx_data <= d;
    @(posedge pclk);
    tx_wr <= 1'b0;
    @(negedge pclk);
    chk(shift_load, 1);
  endtask

  // ******************************
  // sequence
  // ******************************
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, bit_tick, data_rd} = '0;
    {tx_wr, tx_data, brk_req, inv, send_low, num_errors, samples_checked} = '0;
    rx_char = '0;
    ce = 1'b1;
    tx_serial = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 6; a++)
    begin
      apb(0, 8'(a * 4), 0);
      chk(q, ULS_REG_RST);
    end
    apb(0, 8'h18, 0);
    chk(e, 1);
    chk(q, 0);
    apb(1, ULS_CTL3_ADDR, 32'hff);
    apb(0, ULS_CTL3_ADDR, 0);
    chk(q, 32'h7f);
    apb(1, ULS_STAT2_ADDR, 32'hff);
    apb(0, ULS_STAT2_ADDR, 0);
    chk(q, 32'h1e);
    apb(1, ULS_CTL3_ADDR, 0);
    for (int i = 0; i < 2; i++)
    begin
      inv <= i[0];
      apb(1, ULS_STAT2_ADDR, 32'(i * 16));
      tick(11);
      apb(1, ULS_STAT2_ADDR, 32'(8'h40 + i * 16));
      apb(1, ULS_IRQ_CLR_ADDR, 7);
      send_low <= 1'b1;
      repeat (8) @(posedge pclk);
      chk(rx_line, 0);
      apb(0, ULS_STAT2_ADDR, 0);
      chk(q, 32'h41 + i * 16);
      send_low <= 1'b0;
      tick(11);
      apb(0, ULS_STAT2_ADDR, 0);
      chk(q[0], 0);
      apb(0, ULS_IRQ_STAT_ADDR, 0);
      chk(q[2], 1);
    end
    inv <= 1'b0;
    apb(1, ULS_IRQ_EN_ADDR, 1);
    for (int m = 0; m < 2; m++)
    begin
      apb(1, ULS_AUX_ADDR, 32'(m));
      apb(1, ULS_STAT2_ADDR, 32'h2);
      tick(12);
      apb(1, ULS_STAT2_ADDR, 32'hc2);
      apb(1, ULS_IRQ_CLR_ADDR, 7);
      send_low <= 1'b1;
      repeat (6) @(posedge pclk);
      tick(10 + m);
      apb(0, ULS_STAT2_ADDR, 0);
      chk({q[7], ev_irq}, 0);
      tick(1);
      apb(0, ULS_STAT2_ADDR, 0);
      chk({q[7], ev_irq}, 3);
      send_low <= 1'b0;
      apb(1, ULS_IRQ_CLR_ADDR, 1);
      repeat (3) @(posedge pclk);
      chk(ev_irq, 0);
    end
    pulse_rd();
    char(4'h0);
    chk(err_flags, 0);
    for (int w = 0; w < 2; w++)
    begin
      apb(1, ULS_STAT2_ADDR, 32'(w * 8));
      apb(1, ULS_AUX_ADDR, 2);
      pulse_rd();
      send_low <= 1'b1;
      repeat (8) @(posedge pclk);
      send_low <= 1'b0;
      tick(11);
      chk(err_flags.idle, w);
    end
    apb(1, ULS_AUX_ADDR, 0);
    pulse_rd();
    for (int i = 0; i < 4; i++)
    begin
      apb(1, ULS_CTL3_ADDR, 0);
      char(fault[i]);
      if (i == 3)
        char(fault[i]);
      chk(err_flags, fexp[i]);
      chk(err_irq, 0);
      apb(1, ULS_CTL3_ADDR, 32'(1 << i));
      repeat (2) @(posedge pclk);
      chk(err_irq, 1);
      pulse_rd();
      chk({err_irq, err_flags}, 0);
    end
    apb(1, ULS_AUX_ADDR, 1);
    char(4'hc);
    apb(0, ULS_CTL3_ADDR, 0);
    chk(q[7], 1);
    pulse_rd();
    apb(1, ULS_CTL3_ADDR, 32'h40);
    txw(8'ha5);
    chk(shift_word, 9'h1a5);
    txw(8'h3c);
    chk(shift_word, 9'h13c);
    apb(1, ULS_CTL3_ADDR, 0);
    for (int k = 0; k < 4; k++)
    begin
      apb(1, ULS_AUX_ADDR, 32'(k % 2));
      apb(1, ULS_STAT2_ADDR, 32'((k / 2) * 4));
      @(posedge pclk);
      brk_req <= 1'b1;
      @(posedge pclk);
      brk_req <= 1'b0;
      @(negedge pclk);
      chk(tx_brk_busy, 1);
      repeat (2) @(posedge pclk);
      chk(tx_pin_o, 0);
      n = 0;
      while (tx_brk_busy === 1'b1 && n < 20)
      begin
        tick(1);
        @(posedge pclk);
        n++;
      end
      chk(n, 10 + k % 2 + 3 * (k / 2));
    end
    apb(1, ULS_CTL3_ADDR, 32'h10);
    repeat (3) @(posedge pclk);
    chk(tx_pin_o, 0);
    tx_serial <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(tx_pin_o, 1);
    for (int k = 0; k < 3; k++)
    begin
      apb(1, ULS_AUX_ADDR, (k == 2) ? 32'h0 : 32'hc);
      apb(1, ULS_CTL3_ADDR, (k == 1) ? 32'h20 : 32'h0);
      repeat (2) @(posedge pclk);
      chk(tx_pin_oe, k != 0);
    end
    // ce low must hold every flop, so a break request goes unseen
    ce <= 1'b0;
    @(posedge pclk);
    brk_req <= 1'b1;
    @(posedge pclk);
    brk_req <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(tx_brk_busy, 0);
    ce <= 1'b1;
    // mid-run reset brings pins, requests and flags back to idle
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({tx_pin_o, tx_pin_oe, err_irq, ev_irq}, 4'hc);
    presetn <= 1'b1;
    apb(0, ULS_STAT2_ADDR, 0);
    chk(q, ULS_REG_RST);
    report_and_stop();
  end
endmodule
`default_nettype wire
